// *** bench/lbst_block_bench.sv ***
// self-checking bench for the logic block storage section
`timescale 1ns/1ps
`default_nettype none
module lbst_block_bench;
   import lbst_pkg::*;
   logic             clk_i = 1'b0, rst_i = 1'b1, blk_clk = 1'b0, gate = 1'b0;
   logic             aclr = 1'b0, gpin = 1'b0, gnode = 1'b0, soe = 1'b0;
   logic             pull_high = 1'b0, casc_in = 1'b0, casc_o, c, rd_seen = 1'b0;
   lbst_bus_req_type bus = '0;
   logic [15:0]      lut_in = '0, oe;
   logic [1:0]       fsel = '0, five_o;
   logic [3:0]       byp = '0, drv = '0, sense, keep, byp_o, comb_o, q_o, d, qe, l;
   logic [31:0]      rdata, lo, hi, cfgv, route, exp_q[$], msk_q[$];
   lbst_longline_type ll;
   int               fails = 0, compares = 0, seed;

   lbst_block dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
      .lut_in_i(lut_in), .five_sel_i(fsel), .cascade_in_i(casc_in),
      .cascade_out_o(casc_o), .bypass_input_pin_i(byp), .bypass_out_o(byp_o),
      .comb_out_o(comb_o), .five_input_combiner_o(five_o), .stored_out_o(q_o),
      .blk_clk_i(blk_clk), .clock_gate_i(gate), .async_clear_input_i(aclr),
      .gclr_pin_i(gpin), .gclr_node_i(gnode), .shared_output_enable_i(soe),
      .longline_driver_in_i(drv), .longline_sense_i(sense), .longline_o(ll),
      .keeper_level_o(keep));
   lbst_far_side far (.longline_i(ll), .keeper_i(keep), .pull_high_i(pull_high),
      .sense_o(sense));

   always #4 clk_i = ~clk_i;

   // ****
   // result watcher: read data belongs to the cycle after the strobe only
   // ****
   always @(posedge clk_i) rd_seen <= bus.rd;
   always @(negedge clk_i) begin
      if (rd_seen) check("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
      else check("idle rdata", rdata, 32'h0000_0000);
   end

   task automatic check(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // gap cycle after each strobe so no signal is assigned twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // stored outputs seen through the status word, after edge detect settles
   task automatic stq(input logic [31:0] e);
      tick(3);
      rd(LBST_OFS_STATUS, e, 32'h0000_020f);
   endtask

   task automatic endt(input string s);
      $display("test %s done", s);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // lookup outputs worked out from the written tables and the inputs
   function automatic logic [3:0] lutv();
      logic [15:0] w;
      for (int n = 0; n < 4; n++) begin
         w = n < 2 ? lo[16*n +: 16] : hi[16*(n-2) +: 16];
         lutv[n] = w[lut_in[4*n +: 4]];
      end
   endfunction

   initial begin
      #40000;
      fails++;
      summarize();
   end

   initial begin
      seed = $urandom(83);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(LBST_OFS_LUT_LO, LBST_RST_LUT, '1);
      rd(LBST_OFS_CFG, LBST_RST_CFG, '1);
      rd(LBST_OFS_ROUTE, LBST_RST_ROUTE, '1);
      wr(8'h14, 32'hffff_ffff);
      rd(8'h14, 32'h0000_0000, '1);
      stq(32'h0000_0000);
      endt("reset");
      // combinational paths with random tables and inputs
      lo = $urandom;
      hi = $urandom;
      cfgv = 32'h0000_0f00 | ($urandom & 32'h0f00_0000);
      wr(LBST_OFS_LUT_LO, lo);
      wr(LBST_OFS_LUT_HI, hi);
      wr(LBST_OFS_CFG, cfgv);
      for (int i = 0; i < 16; i++) begin
         lut_in <= 16'($urandom);
         byp <= 4'($urandom);
         fsel <= 2'($urandom);
         casc_in <= 1'($urandom);
         tick(1);
         l = lutv();
         c = casc_in;
         for (int n = 0; n < 4; n++) c = l[n] ? c : cfgv[24+n];
         check("comb", 32'(comb_o), 32'(l));
         check("bypass", 32'(byp_o), 32'(byp));
         check("five", 32'(five_o), {30'h0, fsel[1] ? l[3] : l[2], fsel[0] ? l[1] : l[0]});
         check("cascade", 32'(casc_o), 32'(c));
      end
      endt("combinational");
      // flip-flops, mixed polarity, data from bypass on 0 and 1
      wr(LBST_OFS_CFG, 32'h0003_0fa0);
      for (int k = 0; k < 2; k++) begin
         byp <= 4'($urandom);
         lut_in <= 16'($urandom);
         tick(1);
         d = (byp & 4'h3) | (lutv() & 4'hc);
         blk_clk <= ~blk_clk;
         qe = k == 0 ? (d & 4'h5) : ((qe & 4'h5) | (d & 4'ha));
         stq({28'h0, qe});
      end
      endt("flip-flop");
      // gate in use: held low for two edges, then high
      wr(LBST_OFS_CFG, 32'h0003_ffa0);
      qe = 4'h0;
      for (int k = 0; k < 3; k++) begin
         gate <= k == 2;
         byp <= 4'($urandom);
         tick(1);
         if (k == 2) qe = ((byp & 4'h3) | (lutv() & 4'hc)) & 4'h5;
         blk_clk <= ~blk_clk;
         stq({28'h0, qe});
      end
      endt("gate");
      // latches: rising ones open while clock low, falling ones while high
      blk_clk <= 1'b0;
      tick(2);
      wr(LBST_OFS_CFG, 32'h000f_0f3f);
      byp <= 4'($urandom);
      tick(1);
      qe = {byp[3:2], 2'b00};
      stq({28'h0, qe});
      blk_clk <= 1'b1;
      byp <= 4'($urandom);
      tick(1);
      qe = {qe[3:2], byp[1:0]};
      stq({28'h0, qe});
      endt("latch");
      // clears: per element enable, reconfiguration, global sources
      wr(LBST_OFS_CFG, 32'h000f_05a0);
      byp <= 4'hf;
      for (int k = 0; k < 5; k++) begin
         aclr <= k == 3;
         blk_clk <= ~blk_clk;
         tick(2);
         if (k == 1) stq(32'h0000_000f);
         if (k == 4) stq(32'h0000_000a);
      end
      aclr <= 1'b0;
      gpin <= 1'b1;
      stq(32'h0000_0200);
      gpin <= 1'b0;
      wr(LBST_OFS_CFG, 32'h000f_05a0);
      stq(32'h0000_0000);
      gnode <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         wr(LBST_OFS_CFG, 32'h000f_05a0 | {2'b00, k[1:0], 28'h0000000});
         blk_clk <= ~blk_clk;
         tick(2);
         blk_clk <= ~blk_clk;
         stq(k == 0 ? 32'h0000_000f : 32'h0000_0200);
      end
      gnode <= 1'b0;
      endt("clear");
      // longline drivers: 0 and 2 in three-state mode
      route = $urandom;
      wr(LBST_OFS_ROUTE, route);
      wr(LBST_OFS_CFG, 32'h0050_0f00);
      for (int k = 0; k < 4; k++) begin
         soe <= k[0];
         drv <= 4'($urandom);
         tick(2);
         for (int n = 0; n < 4; n++) oe[4*n +: 4] = route[4*n +: 4] & {4{n[0] | ~soe}};
         check("oe", 32'(ll.oe), 32'(oe));
         check("line data", 32'(ll.data), 32'(drv));
      end
      wr(LBST_OFS_ROUTE, 32'h0000_ffff);
      wr(LBST_OFS_CFG, 32'h00f0_0f00);
      soe <= 1'b0;
      drv <= 4'($urandom);
      tick(3);
      d = drv;
      check("keeper", 32'(keep), 32'(d));
      soe <= 1'b1;
      drv <= ~d;
      tick(3);
      check("keeper hold", 32'(keep), 32'(d));
      pull_high <= 1'b1;
      tick(3);
      rd(LBST_OFS_STATUS, 32'h0000_3c00, 32'h0000_3c00);
      endt("longline");
      summarize();
   end
endmodule
`default_nettype wire

// *** bench/lbst_far_side.sv ***
// far side model: longline wiring with keeper and optional pull-high driver
`timescale 1ns/1ps
`default_nettype none
module lbst_far_side (
   input  wire lbst_pkg::lbst_longline_type longline_i,
   input  wire logic [3:0]                  keeper_i,
   input  wire logic                        pull_high_i,
   output logic [3:0]                       sense_o
);
   import lbst_pkg::*;
   // ****
   // line resolution
   // ****
   // any enabled route wins, else the extra high driver, else the keeper holds
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         if (|longline_i.oe[4*n +: 4])
            sense_o[n] = longline_i.data[n];
         else if (pull_high_i)
            sense_o[n] = 1'b1;
         else
            sense_o[n] = keeper_i[n];
      end
   end
endmodule
`default_nettype wire

// *** rtl/lbst_block.sv ***
// logic block: four cells with storage elements, decode cascade and longline drivers
`timescale 1ns/1ps
`default_nettype none
// *******************************************
// How it works
// - each cell's carry mux feeds the next, four cells form one cascade
// - cascade does general decode; per-cell constants choose and-style or or-style
// - global clear, power-up or reconfiguration force every stored output to zero
// - shared active-high asynchronous clear zeroes each element whose clear is enabled, overriding clock
// - clear can be disabled per element; unconnected clear acts as inactive
// - flip-flop loads data on active edge when gate high and clear low
// - latch passes data while polarised clock low, holds while it is high
// - gate low with clear inactive holds every element whose gate is used, whatever clock does
// - unconnected gate counts as always active; gate cannot be inverted
// - one shared clock, each element picks rising or falling edge
// - element data comes from lookup output or bypass input, per element
// - four bypass inputs feed four bypass outputs with no storage
// - each cell has a combinational output always driven by its lookup
// - storage works as registers while lookups compute unrelated functions
// - global clear comes from a pin, optionally inverted, or an internal node
// - each longline driver is a plain buffer or tri-state under shared enable
// - tri-state driver floats when enable control is one, passes when zero
// - each driver reaches up to two horizontal and two vertical longlines
// - each longline has a keeper holding its last level, yielding to drivers
// - lower and upper cell pairs combine into five-input functions
// *******************************************
module lbst_block #(
   parameter int CELLS = 4
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire lbst_pkg::lbst_bus_req_type bus_i,
   output logic [31:0]                     rdata_o,
   input  wire logic [15:0]                lut_in_i,
   input  wire logic [1:0]                 five_sel_i,
   input  wire logic                       cascade_in_i,
   output logic                            cascade_out_o,
   input  wire logic [3:0]                 bypass_input_pin_i,
   output logic [3:0]                      bypass_out_o,
   output logic [3:0]                      comb_out_o,
   output logic [1:0]                      five_input_combiner_o,
   output logic [3:0]                      stored_out_o,
   input  wire logic                       blk_clk_i,
   input  wire logic                       clock_gate_i,
   input  wire logic                       async_clear_input_i,
   input  wire logic                       gclr_pin_i,
   input  wire logic                       gclr_node_i,
   input  wire logic                       shared_output_enable_i,
   input  wire logic [3:0]                 longline_driver_in_i,
   input  wire logic [3:0]                 longline_sense_i,
   output lbst_pkg::lbst_longline_type     longline_o,
   output logic [3:0]                      keeper_level_o
);
   import lbst_pkg::*;

   // the logic below is written for the four-cell block only
   if (CELLS != 4) begin : g_bad_cells
      $error("lbst_block supports exactly four cells");
   end

   // *******************************************
   // lookup evaluation
   // *******************************************
   function automatic logic lut_eval(input logic [15:0] table_bits, input logic [3:0] sel);
      lut_eval = table_bits[sel];
   endfunction

   // *******************************************
   // configuration registers
   // *******************************************
   logic [31:0] lut_lo;
   logic [31:0] lut_hi;
   logic [31:0] cfg;
   logic [31:0] route;
   logic [31:0] rdata;
   logic [31:0] status;

   wire wr_lut_lo = bus_i.wr && (bus_i.addr == LBST_OFS_LUT_LO);
   wire wr_lut_hi = bus_i.wr && (bus_i.addr == LBST_OFS_LUT_HI);
   wire wr_cfg    = bus_i.wr && (bus_i.addr == LBST_OFS_CFG);
   wire wr_route  = bus_i.wr && (bus_i.addr == LBST_OFS_ROUTE);

   // config writes; a write to LBST_OFS_CFG is also how the cells get reconfigured
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lut_lo <= LBST_RST_LUT;
         lut_hi <= LBST_RST_LUT;
         cfg    <= LBST_RST_CFG;
         route  <= LBST_RST_ROUTE;
      end else begin
         if (wr_lut_lo) lut_lo <= bus_i.wdata;
         if (wr_lut_hi) lut_hi <= bus_i.wdata;
         if (wr_cfg)    cfg    <= bus_i.wdata;
         if (wr_route)  route  <= bus_i.wdata;
      end
   end

   // read mux; unmapped addresses read as zero
   logic [31:0] next_rdata;
   always_comb begin
      case (bus_i.addr)
         LBST_OFS_LUT_LO: next_rdata = lut_lo;
         LBST_OFS_LUT_HI: next_rdata = lut_hi;
         LBST_OFS_CFG:    next_rdata = cfg;
         LBST_OFS_ROUTE:  next_rdata = route;
         LBST_OFS_STATUS: next_rdata = status;
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= bus_i.rd ? next_rdata : 32'h0000_0000;
      end
   end
   assign rdata_o = rdata;

   // *******************************************
   // configuration fields
   // *******************************************
   wire [3:0] latch_mode = cfg[LBST_CFG_LATCH +: 4];
   wire [3:0] fall_pol   = cfg[LBST_CFG_FALL  +: 4];
   wire [3:0] clr_en     = cfg[LBST_CFG_CLREN +: 4];
   wire [3:0] ce_used    = cfg[LBST_CFG_CEUSE +: 4];
   wire [3:0] byp_sel    = cfg[LBST_CFG_DISEL +: 4];
   wire [3:0] tri_mode   = cfg[LBST_CFG_TRI   +: 4];
   wire [3:0] cy_gen     = cfg[LBST_CFG_CYGEN +: 4];
   wire       gclr_src   = cfg[LBST_CFG_GSRC];
   wire       gclr_inv   = cfg[LBST_CFG_GINV];

   // *******************************************
   // lookups, combiners and bypass
   // *******************************************
   logic [3:0] lut_out;
   assign lut_out[0] = lut_eval(lut_lo[15:0],  lut_in_i[3:0]);
   assign lut_out[1] = lut_eval(lut_lo[31:16], lut_in_i[7:4]);
   assign lut_out[2] = lut_eval(lut_hi[15:0],  lut_in_i[11:8]);
   assign lut_out[3] = lut_eval(lut_hi[31:16], lut_in_i[15:12]);

   // lookups stay live whatever the storage elements do
   assign comb_out_o = lut_out;
   // pairs (0,1) and (2,3) widen to five inputs through a 2:1 mux
   assign five_input_combiner_o[0] = five_sel_i[0] ? lut_out[1] : lut_out[0];
   assign five_input_combiner_o[1] = five_sel_i[1] ? lut_out[3] : lut_out[2];
   // feed-through, no storage on the way
   assign bypass_out_o = bypass_input_pin_i;

   // *******************************************
   // decode cascade
   // *******************************************
   // a true lookup passes the chain on; a false one injects the cell's constant,
   // so all-zero constants give and-cascading and all-one give or-cascading
   logic [4:0] casc;
   assign casc[0] = cascade_in_i;
   for (genvar gi = 0; gi < 4; gi++) begin : g_casc
      assign casc[gi+1] = lut_out[gi] ? casc[gi] : cy_gen[gi];
   end
   assign cascade_out_o = casc[4];

   // *******************************************
   // clock, gate and clears
   // *******************************************
   // global clear: pin with optional inversion, or an internal node
   wire gclr = gclr_src ? gclr_node_i : (gclr_pin_i ^ gclr_inv);

   // reconfiguring the storage section counts as reconfiguration
   wire reconf = wr_cfg;

   logic blk_clk_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         blk_clk_q <= 1'b0;
      end else begin
         blk_clk_q <= blk_clk_i;
      end
   end

   wire rise = blk_clk_i & ~blk_clk_q;
   wire fall = ~blk_clk_i & blk_clk_q;

   logic [3:0] next_q;
   logic [3:0] q;
   logic [3:0] clr_eff;
   logic [3:0] ce_eff;
   logic [3:0] load;
   logic [3:0] d_sel;

   for (genvar gi = 0; gi < 4; gi++) begin : g_elem
      // unused clear is inactive, unused gate always active
      assign clr_eff[gi] = async_clear_input_i & clr_en[gi];
      assign ce_eff[gi]  = clock_gate_i | ~ce_used[gi];
      assign d_sel[gi]   = byp_sel[gi] ? bypass_input_pin_i[gi] : lut_out[gi];
      // flip-flop: chosen edge; latch: transparent while polarised clock is low
      assign load[gi] = ce_eff[gi] & (latch_mode[gi]
                        ? ~(blk_clk_i ^ fall_pol[gi])
                        : (fall_pol[gi] ? fall : rise));
      assign next_q[gi] = (gclr | reconf | clr_eff[gi]) ? 1'b0
                          : (load[gi] ? d_sel[gi] : q[gi]);
   end

   // clears are sampled, so they take effect at the next system edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= 4'h0;
      end else begin
         q <= next_q;
      end
   end
   assign stored_out_o = q;

   // *******************************************
   // longline drivers and keepers
   // *******************************************
   // enable control high floats a tri-state driver; plain buffers always drive
   logic [15:0] ll_oe;
   for (genvar gi = 0; gi < 4; gi++) begin : g_lldrv
      wire drive = ~tri_mode[gi] | ~shared_output_enable_i;
      assign ll_oe[gi*4 +: 4] = route[gi*4 +: 4] & {4{drive}};
   end
   assign longline_o.data = longline_driver_in_i;
   assign longline_o.oe   = ll_oe;

   // keepers track the resolved line, so any active driver wins over them;
   // a line that must read high when free needs a user driver for it
   logic [3:0] keeper;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         keeper <= 4'h0;
      end else begin
         keeper <= longline_sense_i;
      end
   end
   assign keeper_level_o = keeper;

   // *******************************************
   // status
   // *******************************************
   always_comb begin
      status = 32'h0000_0000;
      status[LBST_ST_Q    +: 4] = q;
      status[LBST_ST_LUT  +: 4] = lut_out;
      status[LBST_ST_CASC]      = casc[4];
      status[LBST_ST_GCLR]      = gclr;
      status[LBST_ST_KEEP +: 4] = keeper;
   end

   // *******************************************
   // checks
   // *******************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_global_clear: assert property (
      gclr |=> (q == 4'h0))
      else $error("global clear did not zero the elements");

   chk_async_clear: assert property (
      (async_clear_input_i && clr_en[0] && !reconf) |=> !q[0])
      else $error("shared clear did not zero element 0");

   chk_clear_off: assert property (
      (!gclr && !reconf && !clr_en[1] && !load[1]) |=> (q[1] == $past(q[1])))
      else $error("disabled clear disturbed element 1");

   chk_ff_load: assert property (
      (!gclr && !reconf && !clr_eff[0] && !latch_mode[0] && !fall_pol[0]
       && ce_eff[0] && rise) |=> (q[0] == $past(d_sel[0])))
      else $error("flip-flop missed its rising edge load");

   chk_latch_pass: assert property (
      (!gclr && !reconf && !clr_eff[2] && latch_mode[2] && !fall_pol[2]
       && ce_eff[2] && !blk_clk_i) |=> (q[2] == $past(d_sel[2])))
      else $error("latch not transparent with clock low");

   chk_gate_holds: assert property (
      (!gclr && !reconf && !clr_eff[3] && ce_used[3] && !clock_gate_i)
      |=> $stable(q[3]))
      else $error("gated element changed");

   chk_drv_float: assert property (
      (tri_mode[1] && shared_output_enable_i) |-> (ll_oe[7:4] == 4'h0))
      else $error("tri-state driver drove while disabled");

   chk_cascade_and: assert property (
      (lut_out == 4'hf) |-> (cascade_out_o == cascade_in_i))
      else $error("cascade did not pass through four true cells");

   chk_keeper_holds: assert property (
      $stable(longline_sense_i)[*2] |-> (keeper_level_o == longline_sense_i))
      else $error("keeper lost the line level");

   // *******************************************
   // further checks on polarity, selection, gate, drivers, cascade and reconfiguration
   // *******************************************
   // a falling-polarity latch must open on the high clock level
   chk_latch_fall: assert property (
      (!gclr && !reconf && !clr_eff[0] && latch_mode[0] && fall_pol[0]
       && ce_eff[0] && blk_clk_i) |=> (q[0] == $past(d_sel[0])))
      else $error("falling latch not transparent with clock high");

   // a falling-edge flip-flop loads on the falling block clock
   chk_fall_load: assert property (
      (!gclr && !reconf && !clr_eff[1] && !latch_mode[1] && fall_pol[1]
       && ce_eff[1] && fall) |=> (q[1] == $past(d_sel[1])))
      else $error("flip-flop missed its falling edge load");

   // bypass selection must reach the element, not the lookup
   chk_data_select: assert property (
      (!gclr && !reconf && !clr_eff[3] && load[3] && byp_sel[3])
      |=> (q[3] == $past(bypass_input_pin_i[3])))
      else $error("element 3 did not take its bypass input");

   // an unused gate must not block a load while the pin is low
   chk_gate_free: assert property (
      (!gclr && !reconf && !clr_eff[2] && !ce_used[2] && !latch_mode[2]
       && !fall_pol[2] && rise) |=> (q[2] == $past(d_sel[2])))
      else $error("unused gate blocked element 2");

   // a plain buffer ignores the shared enable control entirely
   chk_plain_drive: assert property (
      (!tri_mode[3]) |-> (ll_oe[15:12] == route[15:12]))
      else $error("plain buffer stopped driving");

   // upper inputs of both pairs selected together
   chk_five_pair: assert property (
      (five_sel_i == 2'b11) |-> (five_input_combiner_o == {lut_out[3], lut_out[1]}))
      else $error("five-input combiner picked the wrong cell");

   // four false cells leave the last cell's constant on the chain
   chk_cascade_or: assert property (
      (lut_out == 4'h0) |-> (cascade_out_o == cy_gen[3]))
      else $error("cascade did not take the last constant");

   // rewriting the storage configuration wipes every element
   chk_reconf_clear: assert property (
      reconf |=> (q == 4'h0))
      else $error("reconfiguration did not zero the elements");

endmodule
`default_nettype wire

// *** rtl/lbst_pkg.sv ***
// package: register map, field layout and carriers of the logic block storage section
package lbst_pkg;

   // *******************************************
   // register map (byte addresses)
   // *******************************************
   localparam logic [7:0] LBST_OFS_LUT_LO = 8'h00;
   localparam logic [7:0] LBST_OFS_LUT_HI = 8'h04;
   localparam logic [7:0] LBST_OFS_CFG    = 8'h08;
   localparam logic [7:0] LBST_OFS_ROUTE  = 8'h0c;
   localparam logic [7:0] LBST_OFS_STATUS = 8'h10;

   // *******************************************
   // configuration field positions
   // *******************************************
   localparam int LBST_CFG_LATCH  = 0;
   localparam int LBST_CFG_FALL   = 4;
   localparam int LBST_CFG_CLREN  = 8;
   localparam int LBST_CFG_CEUSE  = 12;
   localparam int LBST_CFG_DISEL  = 16;
   localparam int LBST_CFG_TRI    = 20;
   localparam int LBST_CFG_CYGEN  = 24;
   localparam int LBST_CFG_GSRC   = 28;
   localparam int LBST_CFG_GINV   = 29;

   // status field positions
   localparam int LBST_ST_Q      = 0;
   localparam int LBST_ST_LUT    = 4;
   localparam int LBST_ST_CASC   = 8;
   localparam int LBST_ST_GCLR   = 9;
   localparam int LBST_ST_KEEP   = 10;

   // *******************************************
   // reset values
   // *******************************************
   localparam logic [31:0] LBST_RST_LUT   = 32'h0000_0000;
   localparam logic [31:0] LBST_RST_CFG   = 32'h0000_0f00;
   localparam logic [31:0] LBST_RST_ROUTE = 32'h0000_0000;

   // *******************************************
   // carriers
   // *******************************************
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } lbst_bus_req_type;

   typedef struct packed {
      logic [3:0]  data;   // value offered by each driver
      logic [15:0] oe;     // per driver: h0, h1, v0, v1 (driver 0 in bits 3:0)
   } lbst_longline_type;

endpackage
